// [hw/sdivp_top.v]
// Serial video path and control port of the transmitter front end
// Assumes all inputs synchronous to clock_i; port clock is sampled
`timescale 1ns/1ps
`default_nettype none
`include "sdivp_regs.vh"

module sdivp_top #(
  parameter FIFO_DEPTH = `SDIVP_FIFO_DEPTH,
  parameter FIFO_AW    = 4
) (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire [19:0] parallel_video_in_i,
  input  wire        video_valid_i,
  output wire        video_ready_o,
  input  wire        vertical_blank_i,
  input  wire [4:0]  edh_flags_i,
  input  wire        port_clock_i,
  input  wire        port_target_anc_i,
  input  wire        port_read_i,
  input  wire [9:0]  port_data_i,
  output reg  [9:0]  port_data_o,
  output reg         port_data_oe_o,
  output reg  [4:0]  format_status_o,
  output reg         serial_o
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function [9:0] clip10;
    input [9:0] w;
    input [1:0] cnt;
    begin
      if (w >= 10'h3FC) begin
        clip10 = 10'h3FF;
      end else if ((cnt != 2'h0) && (w <= 10'h003)) begin
        clip10 = 10'h000;
      end else begin
        clip10 = w;
      end
    end
  endfunction

  function [1:0] trs_next;
    input [9:0] w;
    input [1:0] cnt;
    begin
      if (w >= 10'h3FC) begin
        trs_next = 2'h2;
      end else if (cnt != 2'h0) begin
        trs_next = cnt - 2'h1;
      end else begin
        trs_next = 2'h0;
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Control registers and port
  // --------------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_WDATA = 2'h1;
  localparam ST_DRIVE = 2'h2;

  reg [7:0] anc0_q;
  reg [7:0] format0_q;
  reg [7:0] video_option_reg_q;
  reg [1:0] state_q;
  reg [7:0] addr_q;
  reg [1:0] init_cnt_q;
  reg       pclk_q;
  reg [7:0] rd_val;
  wire      prise;
  wire      ctrl_rise;

  assign prise     = port_clock_i & ~pclk_q;
  assign ctrl_rise = prise & ~port_target_anc_i;

  always @* begin
    case (addr_q)
      `SDIVP_ADDR_EDH_FLAGS: rd_val = {3'h0, edh_flags_i};
      `SDIVP_ADDR_ANC0:      rd_val = anc0_q;
      `SDIVP_ADDR_FORMAT0:   rd_val = format0_q;
      `SDIVP_ADDR_FORMAT1:   rd_val = {3'h0, format_status_o};
      `SDIVP_ADDR_VIDEO_OPT: rd_val = video_option_reg_q;
      default:               rd_val = 8'h00;
    endcase
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pclk_q             <= 1'b0;
      init_cnt_q         <= 2'h0;
      state_q            <= ST_IDLE;
      addr_q             <= 8'h00;
      anc0_q             <= `SDIVP_ANC0_RST;
      format0_q          <= `SDIVP_FORMAT0_RST;
      video_option_reg_q <= `SDIVP_VIDEO_OPT_RST;
      port_data_o        <= 10'h000;
      port_data_oe_o     <= 1'b0;
    end else begin
      pclk_q <= port_clock_i;
      if (prise && (init_cnt_q != `SDIVP_INIT_TOGGLES)) begin
        init_cnt_q <= init_cnt_q + 2'h1;
      end else if (ctrl_rise) begin
        case (state_q)
          ST_IDLE: begin
            if (port_data_i[9:8] == `SDIVP_TAG_ADDR) begin
              addr_q <= port_data_i[7:0];
              if (port_read_i) begin
                state_q        <= ST_DRIVE;
                port_data_o    <= {`SDIVP_TAG_RDATA, 8'h00};
                port_data_oe_o <= 1'b1;
              end else begin
                state_q <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            state_q <= ST_IDLE;
            if (port_data_i[9:8] == `SDIVP_TAG_WDATA) begin
              case (addr_q)
                `SDIVP_ADDR_ANC0:      anc0_q <= port_data_i[7:0];
                `SDIVP_ADDR_FORMAT0:   format0_q <= port_data_i[7:0];
                `SDIVP_ADDR_VIDEO_OPT: video_option_reg_q <= port_data_i[7:0];
                default:               anc0_q <= anc0_q;
              endcase
            end
          end
          ST_DRIVE: begin
            state_q        <= ST_IDLE;
            port_data_oe_o <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
      if (state_q == ST_DRIVE && port_data_oe_o) begin
        port_data_o <= {`SDIVP_TAG_RDATA, rd_val};
      end
    end
  end

  // --------------------------------------------------------------------
  // Input buffer
  // --------------------------------------------------------------------
  wire [19:0] fifo_data;
  wire        fifo_valid;
  wire        fifo_ready;

  sdivp_fifo #(
    .WIDTH (20),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (parallel_video_in_i),
    .in_valid_i  (video_valid_i),
    .in_ready_o  (video_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  // --------------------------------------------------------------------
  // Format selection
  // --------------------------------------------------------------------
  reg        det_hd_q;
  reg        hd_mode;
  reg  [4:0] fmt_code;
  wire [4:0] fset;

  assign fset = format0_q[`SDIVP_FSET_MSB:0];

  always @* begin
    if (fset != `SDIVP_FMT_NONE) begin
      hd_mode = (fset == `SDIVP_FMT_HD);
    end else if (format0_q[`SDIVP_STANDARD_DEF_RESTRICT_BIT]) begin
      hd_mode = 1'b0;
    end else if (format0_q[`SDIVP_HIGH_DEF_RESTRICT_BIT]) begin
      hd_mode = 1'b1;
    end else begin
      hd_mode = det_hd_q;
    end
    fmt_code = hd_mode ? `SDIVP_FMT_HD : `SDIVP_FMT_SD;
  end

  // --------------------------------------------------------------------
  // Delay, clipping and dithering
  // --------------------------------------------------------------------
  reg  [19:0] dly_q [0:3];
  reg  [19:0] dly_out;
  reg  [19:0] proc_w;
  reg  [1:0]  trs_lo_q;
  reg  [1:0]  trs_hi_q;
  reg  [7:0]  lfsr_q;
  reg  [2:0]  depth;
  reg  [4:0]  rem_q;
  reg  [19:0] sh_q;
  reg  [8:0]  scr_q;
  reg         dith_on;
  wire        take;
  wire [9:0]  luma_in;
  wire [9:0]  chroma_in;
  wire [9:0]  luma_c;
  wire [9:0]  chroma_c;
  wire        bit_nrz;
  wire        bit_scr;

  assign fifo_ready = (rem_q <= 5'h01);
  assign take       = fifo_ready & fifo_valid;

  always @* begin
    depth = anc0_q[`SDIVP_DEPTH_MSB:0];
    if (depth > `SDIVP_DELAY_MAX) begin
      depth = `SDIVP_DELAY_MAX;
    end
    if (depth == 3'h0) begin
      dly_out = fifo_data;
    end else begin
      dly_out = dly_q[depth[1:0] - 2'h1];
    end
  end

  assign luma_in   = hd_mode ? dly_out[19:10] : 10'h000;
  assign chroma_in = dly_out[9:0];
  assign luma_c    = clip10(luma_in, trs_hi_q);
  assign chroma_c  = clip10(chroma_in, trs_lo_q);

  always @* begin
    dith_on = video_option_reg_q[`SDIVP_DITHER_BIT] &
              (~vertical_blank_i | video_option_reg_q[`SDIVP_VDITHER_BIT]);
    proc_w = {luma_c, chroma_c};
    if (dith_on && (chroma_in < 10'h3FC) && (trs_lo_q == 2'h0)) begin
      proc_w[0] = chroma_c[0] ^ lfsr_q[0];
    end
    if (dith_on && hd_mode && (luma_in < 10'h3FC) && (trs_hi_q == 2'h0)) begin
      proc_w[10] = luma_c[0] ^ lfsr_q[1];
    end
  end

  // --------------------------------------------------------------------
  // Serializer, scrambler and NRZI
  // --------------------------------------------------------------------
  assign bit_nrz = (rem_q != 5'h00) ? sh_q[0] : 1'b0;
  assign bit_scr = bit_nrz ^ scr_q[8] ^ scr_q[3];

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_q[0]        <= 20'h00000;
      dly_q[1]        <= 20'h00000;
      dly_q[2]        <= 20'h00000;
      dly_q[3]        <= 20'h00000;
      trs_lo_q        <= 2'h0;
      trs_hi_q        <= 2'h0;
      lfsr_q          <= 8'h01;
      det_hd_q        <= 1'b0;
      rem_q           <= 5'h00;
      sh_q            <= 20'h00000;
      scr_q           <= 9'h000;
      serial_o        <= 1'b0;
      format_status_o <= `SDIVP_FMT_NONE;
    end else begin
      format_status_o <= fmt_code;
      scr_q           <= {scr_q[7:0], bit_scr};
      serial_o        <= serial_o ^ bit_scr;
      if (rem_q > 5'h01) begin
        rem_q <= rem_q - 5'h01;
        sh_q  <= {1'b0, sh_q[19:1]};
      end else if (take) begin
        rem_q <= hd_mode ? `SDIVP_HD_BITS : `SDIVP_SD_BITS;
        sh_q  <= hd_mode ? proc_w : {10'h000, proc_w[9:0]};
      end else begin
        rem_q <= 5'h00;
      end
      if (take) begin
        dly_q[0] <= fifo_data;
        dly_q[1] <= dly_q[0];
        dly_q[2] <= dly_q[1];
        dly_q[3] <= dly_q[2];
        trs_lo_q <= trs_next(chroma_in, trs_lo_q);
        trs_hi_q <= trs_next(luma_in, trs_hi_q);
        lfsr_q   <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        if (fifo_data[9:0] == 10'h3FF) begin
          det_hd_q <= (fifo_data[19:10] == 10'h3FF);
        end
      end
    end
  end

endmodule // sdivp_top

`default_nettype wire

// [hw/sdivp_regs.vh]
// Constants for the serial video path and its control port
// Assumes inclusion by bare name from the design files
`ifndef SDIVP_REGS_VH
`define SDIVP_REGS_VH

// ----------------------------------------------------------------------
// Control register addresses
// ----------------------------------------------------------------------
`define SDIVP_ADDR_EDH_FLAGS   8'h01
`define SDIVP_ADDR_ANC0        8'h02
`define SDIVP_ADDR_FORMAT0     8'h03
`define SDIVP_ADDR_FORMAT1     8'h04
`define SDIVP_ADDR_VIDEO_OPT   8'h05

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDIVP_DEPTH_MSB        2
`define SDIVP_FSET_MSB         4
`define SDIVP_STANDARD_DEF_RESTRICT_BIT      5
`define SDIVP_HIGH_DEF_RESTRICT_BIT      6
`define SDIVP_DITHER_BIT       0
`define SDIVP_VDITHER_BIT      1

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define SDIVP_ANC0_RST         8'h00
`define SDIVP_FORMAT0_RST      8'h00
`define SDIVP_VIDEO_OPT_RST    8'h00
`define SDIVP_FMT_NONE         5'h00
`define SDIVP_FMT_SD           5'h01
`define SDIVP_FMT_HD           5'h02
`define SDIVP_TAG_ADDR         2'h0
`define SDIVP_TAG_WDATA        2'h3
`define SDIVP_TAG_RDATA        2'h2

// ----------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------
`define SDIVP_INIT_TOGGLES     2'h3
`define SDIVP_DELAY_MAX        3'h4
`define SDIVP_FIFO_DEPTH       16
`define SDIVP_SD_BITS          5'h0A
`define SDIVP_HD_BITS          5'h14

`endif

// [hw/sdivp_fifo.v]
// Word FIFO with registered read data, valid and ready on both sides
// Assumes one clock and an asynchronous active low reset
`timescale 1ns/1ps
`default_nettype none

module sdivp_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output reg              in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  reg [AW:0]      cnt_d;
  wire            push;
  wire            load;

  assign push = in_valid_i & in_ready_o;
  assign load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

  always @* begin
    cnt_d = cnt_q;
    if (push & ~load) begin
      cnt_d = cnt_q + 1'b1;
    end else if (load & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q        <= {AW{1'b0}};
      rp_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      cnt_q      <= cnt_d;
      in_ready_o <= (cnt_d != DEPTH[AW:0]);
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (load) begin
        out_data_o  <= mem[rp_q];
        rp_q        <= rp_q + 1'b1;
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end

endmodule // sdivp_fifo

`default_nettype wire

// [bench/sdivp_top_monitor.sv]
// Port checker for the serial video path, bound to its top
// Assumes sdivp_regs.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "sdivp_regs.vh"
module sdivp_top_monitor (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic [4:0] edh_flags_i,
  input wire logic       port_clock_i,
  input wire logic       port_target_anc_i,
  input wire logic       port_read_i,
  input wire logic [9:0] port_data_i,
  input wire logic [9:0] port_data_o,
  input wire logic       port_data_oe_o,
  input wire logic [4:0] format_status_o,
  input wire logic       video_ready_o
);
  // ------------------------------------------------------------
  // Port access tracking and checks
  // ------------------------------------------------------------
  logic       pc_q, busy_q, wr_q;
  logic [1:0] init_q;
  logic [7:0] addr_q;
  wire        prise = port_clock_i & ~pc_q;
  wire        rise = prise & ~port_target_anc_i;
  wire        go = rise & (init_q == 2'h3);
  wire  [1:0] tag = port_data_i[9:8];
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {pc_q, busy_q, wr_q, init_q, addr_q} <= '0;
    end else begin
      pc_q <= port_clock_i;
      if (rise && init_q != 2'h3) begin
        init_q <= init_q + 2'h1;
      end
      if (go) begin
        busy_q <= ~busy_q & (tag == `SDIVP_TAG_ADDR);
      end
      if (go && !busy_q) begin
        addr_q <= port_data_i[7:0];
        wr_q <= ~port_read_i;
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_init_swallow: assert property (rise && init_q != 2'h3
    |=> !port_data_oe_o) else $error("port answered in init");
  a_read_answer: assert property (go && !busy_q && tag == 2'h0
    && port_read_i |=> port_data_oe_o) else $error("no read answer");
  a_read_tag: assert property (port_data_oe_o
    |-> port_data_o[9:8] == `SDIVP_TAG_RDATA) else $error("bad tag");
  a_drive_holds: assert property (port_data_oe_o && !rise
    |=> port_data_oe_o) else $error("drive ended early");
  a_drive_drops: assert property (port_data_oe_o && rise
    |=> !port_data_oe_o) else $error("drive not released");
  a_anc_ignored: assert property (prise && port_target_anc_i &&
    !busy_q |=> !port_data_oe_o) else $error("anc rise answered");
  a_flags_read: assert property (port_data_oe_o && $past(port_data_oe_o)
    && addr_q == `SDIVP_ADDR_EDH_FLAGS && $stable(edh_flags_i)
    |-> port_data_o[4:0] == edh_flags_i) else $error("flags wrong");
  a_status_code: assert property ($past(rst_n_i) |->
    format_status_o == `SDIVP_FMT_SD || format_status_o == `SDIVP_FMT_HD)
    else $error("bad format code");
  a_forced_hd: assert property (go && busy_q && wr_q &&
    addr_q == `SDIVP_ADDR_FORMAT0 && tag == `SDIVP_TAG_WDATA &&
    port_data_i[4:0] == `SDIVP_FMT_HD |-> ##[1:8]
    format_status_o == `SDIVP_FMT_HD) else $error("force ignored");
  c_read: cover property (go && !busy_q && port_read_i);
  c_full: cover property ($fell(video_ready_o));
  c_anc: cover property (prise && port_target_anc_i);
endmodule // sdivp_top_monitor
bind sdivp_top sdivp_top_monitor sdivp_top_monitor_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .edh_flags_i(edh_flags_i),
  .port_clock_i(port_clock_i), .port_target_anc_i(port_target_anc_i),
  .port_read_i(port_read_i), .port_data_i(port_data_i),
  .port_data_o(port_data_o), .port_data_oe_o(port_data_oe_o),
  .format_status_o(format_status_o), .video_ready_o(video_ready_o));
`default_nettype wire

// [bench/sdivp_host_model.sv]
// Host controller model on the control port
// Assumes the bench resolves the shared port wire with pull-downs
`timescale 1ns/1ps
`default_nettype none
module sdivp_host_model (
  input  wire logic       clock_i,
  input  wire logic [9:0] port_bus_i,
  output var  logic       port_clock_o,
  output var  logic       target_anc_o,
  output var  logic       read_o,
  output var  logic [9:0] drive_data_o,
  output var  logic       drive_en_o,
  output var  logic       got_o,
  output var  logic [9:0] got_data_o
);
  // ------------------------------------------------------------
  // Port cycles, four system clocks per port clock
  // ------------------------------------------------------------
  initial begin
    {port_clock_o, target_anc_o, read_o, drive_en_o, got_o} = '0;
    {drive_data_o, got_data_o} = '0;
  end
  task automatic half();
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic pulse(input logic [9:0] v, input logic en);
    drive_en_o = en;
    drive_data_o = v;
    half();
    port_clock_o = 1'b1;
    @(posedge clock_i);
    #1;
    drive_en_o = 1'b0;
    drive_data_o = ~v;
    @(posedge clock_i);
    #1;
    port_clock_o = 1'b0;
  endtask
  task automatic init_port();
    repeat (3) pulse(10'h000, 1'b0);
  endtask
  task automatic read_reg(input logic anc, input logic [7:0] a);
    target_anc_o = anc;
    read_o = 1'b1;
    pulse({2'b00, a}, 1'b1);
    half();
    got_data_o = port_bus_i;
    got_o = 1'b1;
    @(posedge clock_i);
    #1;
    got_o = 1'b0;
    pulse(10'h000, 1'b0);
  endtask
  task automatic write_reg(input logic anc, input logic [7:0] a,
                           input logic [1:0] t, input logic [7:0] d);
    target_anc_o = anc;
    read_o = 1'b0;
    pulse({2'b00, a}, 1'b1);
    pulse({t, d}, 1'b1);
  endtask
endmodule // sdivp_host_model
`default_nettype wire

// [bench/sdivp_top_tb.sv]
// Self-checking bench for the serial video path and control port
// Assumes design, host model and checker compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
`include "sdivp_regs.vh"
module sdivp_top_tb;
  // ------------------------------------------------------------
  // Stimulus, design, host and result watchers
  // ------------------------------------------------------------
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        video_valid_i = 1'b0;
  logic [19:0] video_i = 20'h00000;
  logic [4:0]  flags = 5'h00;
  logic [31:0] seed = 32'h1C8A;
  logic [9:0]  exp_rd[$], exp_ser[$], sh, w;
  logic [8:0]  hist = 9'h000;
  logic        s_prev = 1'b0, lock = 1'b0, d;
  int          num_errors = 0, n_checks = 0, cnt = 0;
  wire         video_ready_o, port_data_oe_o, serial_o, pclk, anc, rd;
  wire         h_en, got;
  wire  [9:0]  port_data_o, h_data, got_data;
  wire  [4:0]  format_status_o;
  wire  [9:0]  port_bus = port_data_oe_o ? port_data_o :
                          h_en ? h_data : 10'h000;
  always #20 clock_i = ~clock_i;
  sdivp_top sdivp_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .parallel_video_in_i(video_i), .video_valid_i(video_valid_i),
    .video_ready_o(video_ready_o), .vertical_blank_i(seed[3]),
    .edh_flags_i(flags), .port_clock_i(pclk), .port_target_anc_i(anc),
    .port_read_i(rd), .port_data_i(port_bus), .port_data_o(port_data_o),
    .port_data_oe_o(port_data_oe_o), .format_status_o(format_status_o),
    .serial_o(serial_o));
  sdivp_host_model sdivp_host_model_i (.clock_i(clock_i),
    .port_bus_i(port_bus), .port_clock_o(pclk), .target_anc_o(anc),
    .read_o(rd), .drive_data_o(h_data), .drive_en_o(h_en), .got_o(got),
    .got_data_o(got_data));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic vput(input logic [19:0] v);
    int k;
    k = 0;
    video_valid_i = 1'b1;
    video_i = v;
    while (video_ready_o !== 1'b1 && k < 400) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    if (k >= 400)
      num_errors++;
    @(posedge clock_i);
    #1;
  endtask
  task automatic wr_rd(input logic anc_w, input logic [7:0] a,
    input logic [1:0] t, input logic [7:0] v, input logic [7:0] b,
    input logic [9:0] e);
    sdivp_host_model_i.write_reg(anc_w, a, t, v);
    exp_rd.push_back(e);
    sdivp_host_model_i.read_reg(1'b0, b);
  endtask
  always @(posedge clock_i)
    if (got && exp_rd.size() > 0)
      check(got_data, exp_rd.pop_front());
  always @(posedge clock_i) begin
    d = serial_o ^ s_prev ^ hist[3] ^ hist[8];
    hist = {hist[7:0], serial_o ^ s_prev};
    s_prev = serial_o;
    sh = {d, sh[9:1]};
    cnt++;
    if (!lock && exp_ser.size() > 0 && sh == 10'h3FF) begin
      lock = 1'b1;
      cnt = 10;
    end
    if (lock && cnt >= 10) begin
      check(sh, exp_ser.pop_front());
      cnt = 0;
      lock = exp_ser.size() > 0;
    end
  end
  initial begin
    repeat (3) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    sdivp_host_model_i.init_port();
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      w = i == 0 ? 10'h3FC : i == 1 ? 10'h000 : i == 2 ? 10'h003 :
          10'h004 + seed[9:0] % 10'h3F8;
      exp_ser.push_back(i == 0 ? 10'h3FF : i < 3 ? 10'h000 : w);
      vput({1'b0, seed[18:10], w});
    end
    video_valid_i = 1'b0;
    repeat (300) @(posedge clock_i);
    #1;
    check(10'(exp_ser.size()), 10'h000);
    check({9'h000, video_ready_o}, 10'h001);
    flags = seed[4:0];
    for (int a = 1; a < 7; a++) begin
      w = a == 1 ? {5'h10, flags} : a == 4 ? 10'h201 : 10'h200;
      exp_rd.push_back(w);
      sdivp_host_model_i.read_reg(1'b0, a == 6 ? 8'h7E : 8'(a));
    end
    wr_rd(0, `SDIVP_ADDR_VIDEO_OPT, 2'h3, 8'h03, 8'h05, 10'h203);
    wr_rd(0, `SDIVP_ADDR_ANC0, 2'h1, 8'h02, 8'h02, 10'h200);
    wr_rd(1, `SDIVP_ADDR_VIDEO_OPT, 2'h3, 8'h00, 8'h05, 10'h203);
    wr_rd(0, `SDIVP_ADDR_EDH_FLAGS, 2'h3, 8'hFF, 8'h01,
          {5'h10, flags});
    wr_rd(0, `SDIVP_ADDR_ANC0, 2'h3, 8'h04, 8'h02, 10'h204);
    exp_rd.push_back(10'h000);
    sdivp_host_model_i.read_reg(1'b1, `SDIVP_ADDR_VIDEO_OPT);
    wr_rd(0, `SDIVP_ADDR_FORMAT0, 2'h3, 8'h02, 8'h04, 10'h202);
    wr_rd(0, `SDIVP_ADDR_FORMAT0, 2'h3, 8'h01, 8'h04, 10'h201);
    wr_rd(0, `SDIVP_ADDR_FORMAT0, 2'h3, 8'h40, 8'h04, 10'h202);
    wr_rd(0, `SDIVP_ADDR_FORMAT0, 2'h3, 8'h60, 8'h04, 10'h201);
    sdivp_host_model_i.write_reg(0, `SDIVP_ADDR_FORMAT0, 2'h3, 8'h00);
    vput(20'hFFFFF);
    video_valid_i = 1'b0;
    exp_rd.push_back(10'h202);
    sdivp_host_model_i.read_reg(1'b0, `SDIVP_ADDR_FORMAT1);
    repeat (4) @(posedge clock_i);
    #1;
    check({5'h00, format_status_o}, 10'h002);
    check(10'(exp_rd.size()), 10'h000);
    results();
  end
  initial begin
    #(40 * 20000);
    num_errors++;
    results();
  end
endmodule // sdivp_top_tb
`default_nettype wire
